// ==== hdl/acr_rx.sv ====
`timescale 1ns/1ps
// Purpose: control unit end: command receiver, mode state, jet switching
// Assumes: sensor words are samples on clk; link lines and power_ok are async
// Notes:   axis index 0 pitch, 1 yaw, 2 roll
//
// Functional notes
// - link is enable, data and strobe lines
// - each command word is fourteen bits
// - first bit is zero and ignored
// - second bit is the parity bit
// - parity over the word is odd
// - eight data bits, four address, nine blocks
// - transfer clock is logic clock halved
// - sender times bits from same reference
// - shift only while enable and strobe high
// - transfer pulse follows strobe, parity passed only
// - transfer pulse decodes address, applies data
// - long dropout initializes, short one preserves
// - preaim word sets seven-bit gimbal bias
// - one output by polarity above threshold
// - output rises within toggle period
// - jet stays on at least 20 ms
// - jet drops within 20 ms below threshold
// - derived rate damping switched by command
// - pitch/yaw source: acquisition, cruise or inertial
// - roll source selectable, rates individually inhibitable
// - twelve valve drive outputs
module acr_rx
  import acr_pkg::*;
#(
  parameter int unsigned LOGIC_DIV_P   = LOGIC_DIV,
  parameter int unsigned DROPOUT_CYC_P = DROPOUT_CYC,
  parameter int unsigned TOGGLE_CYC_P  = TOGGLE_CYC
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  acr_if.receiver                             link,
  input  wire logic                           power_ok,
  input  wire logic signed [1:0][ERR_W-1:0]   acq_sun_err,
  input  wire logic signed [1:0][ERR_W-1:0]   cruise_sun_err,
  input  wire logic signed [2:0][ERR_W-1:0]   inertial_pos,
  input  wire logic signed [ERR_W-1:0]        tracker_roll_err,
  input  wire logic signed [2:0][ERR_W-1:0]   inertial_rate,
  output logic                     [11:0]     valve_drive,
  output logic                     [2:0]      jet_on_pos,
  output logic                     [2:0]      jet_on_neg,
  output logic                     [6:0]      pitch_preaim,
  output logic                     [6:0]      yaw_preaim,
  output logic                                steer_enable,
  output logic                                steer_high_gain,
  output logic                                transfer_pulse,
  output logic                                word_rejected,
  output logic                                logic_init
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {power_ok, link.cmd_enable_line, link.cmd_strobe_line, link.cmd_data_line};
      pin_sync <= pin_meta;
    end
  end
  logic pwr_s, en_s, stb_s, dat_s;
  assign {pwr_s, en_s, stb_s, dat_s} = pin_sync;

  ////////////////////////////////////////////////////////////////////////
  // logic clock and transfer clock
  logic [19:0] div_cnt;
  logic        phase;
  logic        logic_tick;
  logic        xfer_tick;
  assign logic_tick = (div_cnt == 20'(LOGIC_DIV_P - 1));
  assign xfer_tick  = logic_tick && !phase;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 20'h0_0000;
      phase   <= 1'b0;
    end else if (logic_tick) begin
      div_cnt <= 20'h0_0000;
      phase   <= !phase;
    end else begin
      div_cnt <= div_cnt + 20'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power dropout detector: only a loss longer than the limit re-initializes
  logic [23:0] drop_cnt;
  logic        dropped;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drop_cnt <= 24'h00_0000;
      dropped  <= 1'b1;
    end else if (pwr_s) begin
      drop_cnt <= 24'h00_0000;
      dropped  <= 1'b0;
    end else if (drop_cnt == 24'(DROPOUT_CYC_P - 1)) begin
      dropped  <= 1'b1;
    end else begin
      drop_cnt <= drop_cnt + 24'h00_0001;
    end
  end
  assign logic_init = dropped;

  ////////////////////////////////////////////////////////////////////////
  // command input register
  acr_rx_state_t          rx_state;
  logic [CMD_BITS-1:0]    cmd_word;
  logic [3:0]             bit_cnt;
  logic                   xfer;
  logic                   par_ok;
  logic [3:0]             blk;
  logic [7:0]             dat;
  assign par_ok = acr_odd_ok(cmd_word[BIT_PAR:0]);
  assign blk    = cmd_word[ADDR_MSB:0];
  assign dat    = cmd_word[DATA_MSB:DATA_LSB];
  // the zero lead bit is shifted in but never examined
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      cmd_word <= 14'h0000;
      bit_cnt  <= 4'h0;
      xfer     <= 1'b0;
      word_rejected <= 1'b0;
    end else begin
      xfer          <= 1'b0;
      word_rejected <= 1'b0;
      if (dropped) begin
        rx_state <= RX_IDLE;
        bit_cnt  <= 4'h0;
      end else if (xfer_tick) begin
        case (rx_state)
          RX_IDLE, RX_SHIFT: begin
            if (en_s && stb_s) begin
              cmd_word <= {cmd_word[CMD_BITS-2:0], dat_s};
              bit_cnt  <= (bit_cnt == FULL_CNT) ? bit_cnt : bit_cnt + 4'h1;
              rx_state <= RX_SHIFT;
            end else if (!en_s && stb_s && rx_state == RX_SHIFT) begin
              // strobe held past enable: one transfer, only when checked
              xfer          <= (bit_cnt == FULL_CNT) && par_ok;
              word_rejected <= !((bit_cnt == FULL_CNT) && par_ok);
              rx_state      <= RX_HOLD;
            end else begin
              bit_cnt  <= 4'h0;
              rx_state <= RX_IDLE;
            end
          end
          RX_HOLD: begin
            if (!stb_s) begin
              bit_cnt  <= 4'h0;
              rx_state <= RX_IDLE;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end
  assign transfer_pulse = xfer;

  ////////////////////////////////////////////////////////////////////////
  // decoded mode state, written on a transfer pulse or reloaded on a dropout
  logic [1:0] pitch_src, yaw_src;
  logic       roll_iru;
  logic [2:0] rate_inh;
  logic       dr_en;
  logic [5:0] jet_en;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pitch_src <= RST_PY_SRC;
      yaw_src   <= RST_PY_SRC;
      roll_iru  <= RST_ROLL_IRU;
      rate_inh  <= RST_RATE_INH;
      dr_en     <= RST_DR_EN;
      jet_en    <= RST_JET_EN;
      pitch_preaim <= RST_PREAIM;
      yaw_preaim   <= RST_PREAIM;
      {steer_high_gain, steer_enable} <= RST_STEER;
    end else if (dropped || (xfer && blk == BLK_CLEAR)) begin
      pitch_src <= RST_PY_SRC;
      yaw_src   <= RST_PY_SRC;
      roll_iru  <= RST_ROLL_IRU;
      rate_inh  <= RST_RATE_INH;
      dr_en     <= RST_DR_EN;
      jet_en    <= RST_JET_EN;
      pitch_preaim <= RST_PREAIM;
      yaw_preaim   <= RST_PREAIM;
      {steer_high_gain, steer_enable} <= RST_STEER;
    end else if (xfer) begin
      case (blk)
        BLK_PY_POS:   {yaw_src, pitch_src} <= dat[3:0];
        BLK_ROLL_POS: roll_iru <= dat[0];
        BLK_RATE_INH: rate_inh <= dat[2:0];
        BLK_DERIVED:  dr_en <= dat[0];
        BLK_JET_EN:   jet_en <= dat[5:0];
        BLK_PREAIM_P: pitch_preaim <= dat[6:0];
        BLK_PREAIM_Y: yaw_preaim <= dat[6:0];
        BLK_STEER:    {steer_high_gain, steer_enable} <= dat[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-axis position selection, summing and switching stage
  function automatic logic signed [ERR_W-1:0] pick_src(
    input logic [1:0]               src,
    input logic signed [ERR_W-1:0]  acq,
    input logic signed [ERR_W-1:0]  cru,
    input logic signed [ERR_W-1:0]  inertial_unit
  );
    case (src)
      SRC_ACQ:      return acq;
      SRC_CRUISE:   return cru;
      SRC_INERTIAL: return inertial_unit;
      default:      return '0;
    endcase
  endfunction

  logic signed [2:0][ERR_W-1:0] pos_sel;
  assign pos_sel[0] = pick_src(pitch_src, acq_sun_err[0], cruise_sun_err[0], inertial_pos[0]);
  assign pos_sel[1] = pick_src(yaw_src, acq_sun_err[1], cruise_sun_err[1], inertial_pos[1]);
  assign pos_sel[2] = roll_iru ? inertial_pos[2] : tracker_roll_err;

  for (genvar ax = 0; ax < 3; ax++) begin : g_axis
    logic signed [ERR_W-1:0] drate;
    logic signed [SUM_W-1:0] sum;
    logic [23:0]             hold_cnt;
    logic                    above, below;
    // rate inhibit zeroes the rate term before the summing junction
    assign sum = SUM_W'($signed(pos_sel[ax]))
               + (rate_inh[ax] ? '0 : SUM_W'($signed(inertial_rate[ax])))
               + SUM_W'(drate);
    assign above = sum > THRESH;
    assign below = sum < -THRESH;

    // derived rate: opposes the firing jet so it cannot latch itself on
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        drate <= '0;
      end else if (!dr_en || dropped) begin
        drate <= '0;
      end else if (logic_tick) begin
        drate <= drate - (drate >>> 3)
               - (jet_on_pos[ax] ? DR_STEP : 12'sh000) + (jet_on_neg[ax] ? DR_STEP : 12'sh000);
      end
    end

    // a jet turns on at once and holds for the full toggle period, so the
    // shortest pulse is bounded and release lags the input by under 20 ms
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        jet_on_pos[ax] <= 1'b0;
        jet_on_neg[ax] <= 1'b0;
        hold_cnt       <= 24'h00_0000;
      end else if (dropped) begin
        jet_on_pos[ax] <= 1'b0;
        jet_on_neg[ax] <= 1'b0;
        hold_cnt       <= 24'h00_0000;
      end else if (!jet_on_pos[ax] && !jet_on_neg[ax]) begin
        jet_on_pos[ax] <= above;
        jet_on_neg[ax] <= below;
        hold_cnt       <= 24'(TOGGLE_CYC_P - 1);
      end else if (hold_cnt != 24'h00_0000) begin
        hold_cnt <= hold_cnt - 24'h00_0001;
      end else begin
        jet_on_pos[ax] <= jet_on_pos[ax] && above;
        jet_on_neg[ax] <= jet_on_neg[ax] && below;
      end
    end

    // two drivers per polarity, one per jet assembly
    for (genvar k = 0; k < 4; k++) begin : g_valve
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          valve_drive[ax*4+k] <= 1'b0;
        end else begin
          valve_drive[ax*4+k] <= (k < 2 ? jet_on_pos[ax] : jet_on_neg[ax])
                               && jet_en[ax*2+(k%2)];
        end
      end
    end
  end

endmodule

// ==== hdl/acr_tx.sv ====
`timescale 1ns/1ps
// Purpose: sequencer end: serialises one command word onto the link
// Assumes: same clock, same reset release and same divider as the receiver
// Notes:   lines change on the logic tick opposite the receiver's sample tick
module acr_tx
  import acr_pkg::*;
#(
  parameter int unsigned LOGIC_DIV_P = LOGIC_DIV
) (
  input  wire logic        clk,
  input  wire logic        rst,
  acr_if.sender            link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [3:0]  cmd_block,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_bad_parity
);

  ////////////////////////////////////////////////////////////////////////
  // bit timing from the shared reference
  logic [19:0] div_cnt;
  logic        phase;
  logic        act;
  assign act = (div_cnt == 20'(LOGIC_DIV_P - 1)) && phase;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 20'h0_0000;
      phase   <= 1'b0;
    end else if (div_cnt == 20'(LOGIC_DIV_P - 1)) begin
      div_cnt <= 20'h0_0000;
      phase   <= !phase;
    end else begin
      div_cnt <= div_cnt + 20'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // word framing
  acr_tx_state_t       tx_state;
  logic [CMD_BITS-1:0] shreg;
  logic [3:0]          sent;
  logic                par;
  // parity chosen so parity, data and address hold an odd count of ones
  assign par = !(^{cmd_data, cmd_block}) ^ cmd_bad_parity;
  assign cmd_ready = (tx_state == TX_IDLE) && act;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      shreg    <= 14'h0000;
      sent     <= 4'h0;
      link.cmd_enable_line <= 1'b0;
      link.cmd_strobe_line <= 1'b0;
      link.cmd_data_line   <= 1'b0;
    end else if (act) begin
      case (tx_state)
        TX_IDLE: begin
          if (cmd_valid) begin
            // zero lead, parity, d1..d8, a1..a4
            shreg    <= {1'b0, par, cmd_data, cmd_block};
            sent     <= 4'h0;
            link.cmd_data_line   <= 1'b0;
            link.cmd_enable_line <= 1'b1;
            link.cmd_strobe_line <= 1'b1;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (sent == LAST_BIT) begin
            link.cmd_enable_line <= 1'b0;
            tx_state <= TX_STROBE;
          end else begin
            shreg <= {shreg[CMD_BITS-2:0], 1'b0};
            link.cmd_data_line <= shreg[CMD_BITS-2];
            sent  <= sent + 4'h1;
          end
        end
        TX_STROBE: begin
          link.cmd_strobe_line <= 1'b0;
          link.cmd_data_line   <= 1'b0;
          tx_state <= TX_GAP;
        end
        TX_GAP:  tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

endmodule

// ==== include/acr_if.sv ====
`timescale 1ns/1ps
// Purpose: three-wire command link between sequencer and control unit
// Assumes: all three lines are driven only by the sequencer end
// Notes:   levels change only on the sender's half of the transfer period
interface acr_if;
  logic cmd_enable_line;
  logic cmd_data_line;
  logic cmd_strobe_line;

  modport sender (
    output cmd_enable_line,
    output cmd_data_line,
    output cmd_strobe_line
  );

  modport receiver (
    input cmd_enable_line,
    input cmd_data_line,
    input cmd_strobe_line
  );
endinterface

// ==== include/acr_pkg.sv ====
// Purpose: shared constants and types for the attitude command link
// Assumes: one 250 MHz clock at both ends; both ends leave reset together
// Notes:   a 14-bit word is bit 13 first: zero, parity, d1..d8, a1..a4
package acr_pkg;
  // word layout
  localparam int CMD_BITS = 14;
  localparam int BIT_ZERO = 13;
  localparam int BIT_PAR  = 12;
  localparam int DATA_MSB = 11;
  localparam int DATA_LSB = 4;
  localparam int ADDR_MSB = 3;
  localparam logic [3:0] LAST_BIT = 4'hd;
  localparam logic [3:0] FULL_CNT = 4'he;

  // timing
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned LOGIC_HZ    = 2400;
  localparam int unsigned LOGIC_DIV   = CLK_HZ / LOGIC_HZ;
  localparam int unsigned DROPOUT_MS  = 5;
  localparam int unsigned DROPOUT_CYC = (CLK_HZ / 1000) * DROPOUT_MS;
  localparam int unsigned TOGGLE_MS   = 20;
  localparam int unsigned TOGGLE_CYC  = (CLK_HZ / 1000) * TOGGLE_MS;

  // command block addresses (nine blocks)
  localparam logic [3:0] BLK_PY_POS   = 4'h1;
  localparam logic [3:0] BLK_ROLL_POS = 4'h2;
  localparam logic [3:0] BLK_RATE_INH = 4'h3;
  localparam logic [3:0] BLK_DERIVED  = 4'h4;
  localparam logic [3:0] BLK_JET_EN   = 4'h5;
  localparam logic [3:0] BLK_PREAIM_P = 4'h6;
  localparam logic [3:0] BLK_PREAIM_Y = 4'h7;
  localparam logic [3:0] BLK_STEER    = 4'h8;
  localparam logic [3:0] BLK_CLEAR    = 4'h9;

  // position source codes
  localparam logic [1:0] SRC_ACQ      = 2'h0;
  localparam logic [1:0] SRC_CRUISE   = 2'h1;
  localparam logic [1:0] SRC_INERTIAL = 2'h2;

  // reset values of decoded control state
  localparam logic [1:0] RST_PY_SRC   = SRC_ACQ;
  localparam logic       RST_ROLL_IRU = 1'b0;
  localparam logic [2:0] RST_RATE_INH = 3'h0;
  localparam logic       RST_DR_EN    = 1'b0;
  localparam logic [5:0] RST_JET_EN   = 6'h3f;
  localparam logic [6:0] RST_PREAIM   = 7'h00;
  localparam logic [1:0] RST_STEER    = 2'h0;

  // switching stage arithmetic
  localparam int ERR_W = 12;
  localparam int SUM_W = 15;
  localparam logic signed [SUM_W-1:0] THRESH  = 15'sh0040;
  localparam logic signed [ERR_W-1:0] DR_STEP = 12'sh020;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_SHIFT = 3'b010,
    RX_HOLD  = 3'b100
  } acr_rx_state_t;

  typedef enum logic [3:0] {
    TX_IDLE   = 4'b0001,
    TX_SHIFT  = 4'b0010,
    TX_STROBE = 4'b0100,
    TX_GAP    = 4'b1000
  } acr_tx_state_t;

  // odd parity over parity bit, data and address
  function automatic logic acr_odd_ok(input logic [BIT_PAR:0] w);
    return ^w;
  endfunction
endpackage

// ==== tb/acr_chk.sv ====
// Purpose: concurrent checks on the command link and the receiver outputs
// Assumes: one clock, async active high reset, bench-sized counts
// Notes:   instantiated beside the link interface, no bind
`timescale 1ns/1ps
module acr_chk #(
  parameter int unsigned LOGIC_DIV_P  = 8,
  parameter int unsigned TOGGLE_CYC_P = 40
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_enable_line,
  input wire logic        cmd_data_line,
  input wire logic        cmd_strobe_line,
  input wire logic        transfer_pulse,
  input wire logic        word_rejected,
  input wire logic        logic_init,
  input wire logic [2:0]  jet_on_pos,
  input wire logic [2:0]  jet_on_neg,
  input wire logic [11:0] valve_drive
);
  localparam int         TAIL  = 2 * LOGIC_DIV_P - 1;
  localparam logic [15:0] FRAME = 16'(28 * LOGIC_DIV_P);
  localparam logic [15:0] MIN_ON = 16'(TOGGLE_CYC_P);
  logic [15:0] en_cnt;
  logic [15:0] on_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // helper counters: cycles the enable line and pitch positive jet stay high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) en_cnt <= 16'h0000;
    else en_cnt <= cmd_enable_line ? en_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) on_cnt <= 16'h0000;
    else on_cnt <= jet_on_pos[0] ? on_cnt + 16'h0001 : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // strobe outlives enable by exactly one transfer period
  sequence s_tail;
    cmd_strobe_line ##TAIL cmd_strobe_line ##1 !cmd_strobe_line;
  endsequence

  a_pulse_excl_reject: assert property (!(transfer_pulse && word_rejected))
    else $error("transfer pulse and reject together");
  a_pulse_in_tail: assert property (transfer_pulse |-> cmd_strobe_line && !cmd_enable_line)
    else $error("transfer pulse outside strobe tail");
  a_pulse_one_cycle: assert property (transfer_pulse |=> !transfer_pulse)
    else $error("transfer pulse longer than one cycle");
  a_init_no_pulse: assert property (logic_init && $past(logic_init) |-> !transfer_pulse)
    else $error("transfer pulse while initialising");
  a_jet_one_polarity: assert property ((jet_on_pos & jet_on_neg) == 3'h0)
    else $error("both polarities on");
  a_jet_min_on: assert property ($fell(jet_on_pos[0]) |-> on_cnt >= MIN_ON)
    else $error("jet on time too short");
  a_valve_after_jet: assert property (valve_drive[1:0] != 2'h0 |-> $past(jet_on_pos[0]))
    else $error("valve drive without jet on");
  a_frame_start_zero: assert property ($rose(cmd_enable_line) |-> cmd_strobe_line && !cmd_data_line)
    else $error("frame does not open with zero bit");
  a_frame_len_bits: assert property ($fell(cmd_enable_line) |-> en_cnt == FRAME)
    else $error("frame length not fourteen bits");
  a_strobe_tail_len: assert property ($fell(cmd_enable_line) |-> s_tail)
    else $error("strobe tail wrong length");
endmodule

// ==== tb/attitude_command_receiver_bench.sv ====
// Purpose: drives sender end, checks receiver end across the three-wire link
// Assumes: shortened divider at both ends, shortened dropout and toggle counts at the receiver
// Notes:   only pitch axis is exercised for switching
`timescale 1ns/1ps
module attitude_command_receiver_bench;
  import acr_pkg::*;
  localparam int unsigned DIV = 8;
  localparam int unsigned TOG = 40;
  logic clk, rst, power_ok, cmd_valid, cmd_ready, cmd_bad_parity;
  logic [3:0] cmd_block;
  logic [7:0] cmd_data;
  logic signed [1:0][ERR_W-1:0] acq_sun_err, cruise_sun_err;
  logic signed [2:0][ERR_W-1:0] inertial_pos, inertial_rate;
  logic signed [ERR_W-1:0] tracker_roll_err;
  logic [11:0] valve_drive;
  logic [2:0] jet_on_pos, jet_on_neg;
  logic [6:0] pitch_preaim, yaw_preaim;
  logic steer_enable, steer_high_gain, transfer_pulse, word_rejected, logic_init;
  int bad_count, cmp_count, pulse_n, rej_n;

  acr_if acr_if_i();
  acr_tx #(.LOGIC_DIV_P(DIV)) acr_tx_i (.clk(clk), .rst(rst), .link(acr_if_i.sender),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_block(cmd_block),
    .cmd_data(cmd_data), .cmd_bad_parity(cmd_bad_parity));
  acr_rx #(.LOGIC_DIV_P(DIV), .DROPOUT_CYC_P(50), .TOGGLE_CYC_P(TOG)) acr_rx_i (
    .clk(clk), .rst(rst), .link(acr_if_i.receiver), .power_ok(power_ok),
    .acq_sun_err(acq_sun_err), .cruise_sun_err(cruise_sun_err),
    .inertial_pos(inertial_pos), .tracker_roll_err(tracker_roll_err),
    .inertial_rate(inertial_rate), .valve_drive(valve_drive), .jet_on_pos(jet_on_pos),
    .jet_on_neg(jet_on_neg), .pitch_preaim(pitch_preaim), .yaw_preaim(yaw_preaim),
    .steer_enable(steer_enable), .steer_high_gain(steer_high_gain),
    .transfer_pulse(transfer_pulse), .word_rejected(word_rejected), .logic_init(logic_init));
  acr_chk #(.LOGIC_DIV_P(DIV), .TOGGLE_CYC_P(TOG)) acr_chk_i (.clk(clk), .rst(rst),
    .cmd_enable_line(acr_if_i.cmd_enable_line), .cmd_data_line(acr_if_i.cmd_data_line),
    .cmd_strobe_line(acr_if_i.cmd_strobe_line), .transfer_pulse(transfer_pulse),
    .word_rejected(word_rejected), .logic_init(logic_init), .jet_on_pos(jet_on_pos),
    .jet_on_neg(jet_on_neg), .valve_drive(valve_drive));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (transfer_pulse === 1'h1) pulse_n++;
    if (word_rejected === 1'h1) rej_n++;
  end

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    $display("[FAIL] t=%0t wait limit reached", $time);
    bad_count++;
    complete_run();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // holds the request until ready is seen, then waits for the frame verdict
  task automatic send(input logic [3:0] b, input logic [7:0] d, input logic bp);
    int n, k;
    k = pulse_n + rej_n;
    cmd_block = b;
    cmd_data = d;
    cmd_bad_parity = bp;
    cmd_valid = 1'h1;
    n = 0;
    while (cmd_ready !== 1'h1) begin
      step(1);
      if (++n > 400) hang();
    end
    step(1);
    cmd_valid = 1'h0;
    n = 0;
    while (pulse_n + rej_n == k) begin
      step(1);
      if (++n > 600) hang();
    end
    step(2);
  endtask
  task automatic wait_jet(input logic want);
    int n;
    n = 0;
    while ((jet_on_pos[0] | jet_on_neg[0]) !== want) begin
      step(1);
      if (++n > 200) hang();
    end
  endtask
  task automatic wait_init;
    int n;
    n = 0;
    while (logic_init !== 1'h0) begin
      step(1);
      if (++n > 50) hang();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_words;
    int k;
    k = pulse_n;
    send(BLK_PREAIM_P, 8'h55, 1'h0);
    chk(16'(pulse_n - k), 16'h0001);
    chk(pitch_preaim, 7'h55);
    send(BLK_PREAIM_Y, 8'haa, 1'h0);
    chk(yaw_preaim, 7'h2a);
    k = pulse_n;
    send(BLK_PREAIM_P, 8'h12, 1'h1);
    chk(16'(pulse_n - k), 16'h0000);
    chk(pitch_preaim, 7'h55);
    chk(16'(rej_n), 16'h0001);
    send(4'ha, 8'hff, 1'h0);
    chk({steer_enable, pitch_preaim}, 8'h55);
    send(BLK_STEER, 8'h03, 1'h0);
    chk({steer_enable, steer_high_gain}, 2'h3);
    $display("words test done");
  endtask

  task automatic t_dropout;
    power_ok = 1'h0;
    step(20);
    power_ok = 1'h1;
    step(10);
    chk({logic_init, pitch_preaim}, 8'h55);
    power_ok = 1'h0;
    step(80);
    chk(logic_init, 1'h1);
    power_ok = 1'h1;
    wait_init();
    chk({steer_enable, pitch_preaim, yaw_preaim}, 15'h0000);
    $display("dropout test done");
  endtask

  task automatic t_jets;
    logic p;
    acq_sun_err[0] = 12'sh100;
    wait_jet(1'h1);
    p = jet_on_pos[0];
    chk(jet_on_pos[0] ^ jet_on_neg[0], 1'h1);
    step(2);
    chk(valve_drive[3:0], p ? 4'h3 : 4'hc);
    acq_sun_err[0] = 12'sh000;
    step(20);
    chk(jet_on_pos[0] | jet_on_neg[0], 1'h1);
    wait_jet(1'h0);
    acq_sun_err[0] = -12'sh100;
    wait_jet(1'h1);
    chk(jet_on_pos[0], !p);
    acq_sun_err[0] = 12'sh000;
    wait_jet(1'h0);
    send(BLK_JET_EN, 8'h00, 1'h0);
    acq_sun_err[0] = 12'sh100;
    wait_jet(1'h1);
    step(2);
    chk(valve_drive, 12'h000);
    acq_sun_err[0] = 12'sh000;
    wait_jet(1'h0);
    $display("jets test done");
  endtask

  task automatic t_source;
    send(BLK_PY_POS, 8'h05, 1'h0);
    acq_sun_err[0] = 12'sh100;
    step(20);
    chk(jet_on_pos[0] | jet_on_neg[0], 1'h0);
    acq_sun_err[0] = 12'sh000;
    cruise_sun_err[0] = 12'sh100;
    wait_jet(1'h1);
    cruise_sun_err[0] = 12'sh000;
    wait_jet(1'h0);
    send(BLK_CLEAR, 8'h00, 1'h0);
    acq_sun_err[0] = 12'sh100;
    wait_jet(1'h1);
    acq_sun_err[0] = 12'sh000;
    wait_jet(1'h0);
    // error held above threshold: only the derived rate can end the firing
    send(BLK_DERIVED, 8'h01, 1'h0);
    acq_sun_err[0] = 12'sh100;
    wait_jet(1'h1);
    acq_sun_err[0] = 12'sh050;
    wait_jet(1'h0);
    send(BLK_DERIVED, 8'h00, 1'h0);
    acq_sun_err[0] = 12'sh000;
    wait_jet(1'h0);
    $display("source test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    power_ok = 1'h1;
    {cmd_valid, cmd_bad_parity, cmd_block, cmd_data} = 14'h0000;
    acq_sun_err = '0;
    cruise_sun_err = '0;
    inertial_pos = '0;
    inertial_rate = '0;
    tracker_roll_err = '0;
    step(8);
    chk({logic_init, valve_drive}, 13'h1000);
    rst = 1'h0;
    wait_init();
    t_words();
    t_dropout();
    t_jets();
    t_source();
    complete_run();
  end
endmodule
